// ===== config_status_handshake.sv
// configuration status, done and chain enable handshake sequencer
// assumes pins are open-drain with external pull-ups; rst is power-on reset
// ==========================================================
// Overview of operation
// - done line held low until init starts
// - release done after clean data, init start
// - enter user mode once done pin high and init interval over
// - user mode ignores external done low
// - accept configuration only while chain enable low
// - status low until power-on interval expires
// - early attempt fails; fresh configuration after reset
// - detected error pulls status low
// - external status low errors in load and init only
// - request low discards config, tristates user I/O
// - chain enable out low when configured
module config_status_handshake (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic config_request_n,          // request pin, active low
    input wire logic chain_enable_in_n,         // chain enable pin, active low
    input wire logic config_status_n_in,        // status pin level
    output logic config_status_n_out,           // always 0 when driven
    output logic config_status_n_oe,            // high while pulling low
    input wire logic config_complete_line_in,   // done pin level
    output logic config_complete_line_out,      // always 0 when driven
    output logic config_complete_line_oe,       // high while pulling low
    output logic chain_enable_out_n,            // to next device
    input wire cfg_hs_pkg::load_evt_t load_evt, // data path progress
    output logic load_enable,                   // data path may take data
    output logic user_mode,                     // device configured
    output logic user_io_oe                     // user I/O may drive
);

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [3:0] sync1_ff;   // first stage, read only by second stage
    logic [3:0] sync2_ff;   // second stage
    logic req_n_s, ce_n_s, stat_s, done_s;

    // two flops on every pin; the pins are asynchronous to ref_clk
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_ff <= 4'hF;
            sync2_ff <= 4'hF;
        end else begin
            sync1_ff <= {config_request_n, chain_enable_in_n,
                         config_status_n_in, config_complete_line_in};
            sync2_ff <= sync1_ff;
        end
    end

    assign req_n_s = sync2_ff[3];
    assign ce_n_s = sync2_ff[2];
    assign stat_s = sync2_ff[1];
    assign done_s = sync2_ff[0];   // wired-AND pin, not our own drive

    // ==========================================================
    // sequencer
    // ==========================================================
    cfg_hs_pkg::cfg_state_t state_ff;
    cfg_hs_pkg::cfg_state_t nxt_state;
    logic [cfg_hs_pkg::CNT_W-1:0] cnt_ff;   // por and init timer
    logic cnt_zero;

    assign cnt_zero = (cnt_ff == '0);

    // next state; request low outranks everything once past power-on
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cfg_hs_pkg::ST_POR: begin
                if (cnt_zero) begin
                    nxt_state = cfg_hs_pkg::ST_IDLE;
                end
            end
            cfg_hs_pkg::ST_IDLE: begin
                // only start with chain enabled and status released
                if (!ce_n_s && req_n_s && stat_s) begin
                    nxt_state = cfg_hs_pkg::ST_LOAD;
                end
            end
            cfg_hs_pkg::ST_LOAD: begin
                if (load_evt.data_err || !stat_s) begin
                    nxt_state = cfg_hs_pkg::ST_ERROR;
                end else if (ce_n_s) begin
                    nxt_state = cfg_hs_pkg::ST_IDLE;
                end else if (load_evt.data_done) begin
                    nxt_state = cfg_hs_pkg::ST_INIT;
                end
            end
            cfg_hs_pkg::ST_INIT: begin
                if (!stat_s) begin
                    nxt_state = cfg_hs_pkg::ST_ERROR;
                end else if (done_s && cnt_zero) begin
                    nxt_state = cfg_hs_pkg::ST_USER;
                end
            end
            cfg_hs_pkg::ST_USER: begin
                nxt_state = cfg_hs_pkg::ST_USER;
            end
            cfg_hs_pkg::ST_ERROR: begin
                nxt_state = cfg_hs_pkg::ST_ERROR;       // leave only by request
            end
            cfg_hs_pkg::ST_RESET: begin
                if (req_n_s) begin
                    nxt_state = cfg_hs_pkg::ST_IDLE;
                end
            end
            default: nxt_state = cfg_hs_pkg::ST_POR;
        endcase
        if (!req_n_s && state_ff != cfg_hs_pkg::ST_POR) begin
            nxt_state = cfg_hs_pkg::ST_RESET;
        end
    end

    // state register; rst is the power-on reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= cfg_hs_pkg::ST_POR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // timer: por interval at reset, init interval on entry to init
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_ff <= cfg_hs_pkg::CNT_W'(cfg_hs_pkg::POR_CYCLES - 1);
        end else if (state_ff == cfg_hs_pkg::ST_LOAD && nxt_state == cfg_hs_pkg::ST_INIT) begin
            cnt_ff <= cfg_hs_pkg::CNT_W'(cfg_hs_pkg::INIT_CYCLES - 1);
        end else if (!cnt_zero) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // ==========================================================
    // pin drives, registered
    // ==========================================================
    logic stat_oe_ff, done_oe_ff, ceo_n_ff, user_ff;

    // open-drain drives follow the next state so they change with it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat_oe_ff <= 1'b1;   // status low from power-up
            done_oe_ff <= 1'b1;   // done low from power-up
            ceo_n_ff <= 1'b1;
            user_ff <= 1'b0;
        end else begin
            // status low in por, error and discard
            stat_oe_ff <= (nxt_state == cfg_hs_pkg::ST_POR) ||
                          (nxt_state == cfg_hs_pkg::ST_ERROR) ||
                          (nxt_state == cfg_hs_pkg::ST_RESET);
            // done released only in init and user
            done_oe_ff <= !((nxt_state == cfg_hs_pkg::ST_INIT) ||
                            (nxt_state == cfg_hs_pkg::ST_USER));
            ceo_n_ff <= (nxt_state != cfg_hs_pkg::ST_USER);
            user_ff <= (nxt_state == cfg_hs_pkg::ST_USER);
        end
    end

    assign config_status_n_out = 1'b0;
    assign config_complete_line_out = 1'b0;
    assign config_status_n_oe = stat_oe_ff;
    assign config_complete_line_oe = done_oe_ff;
    assign chain_enable_out_n = ceo_n_ff;
    assign user_mode = user_ff;
    assign user_io_oe = user_ff;   // user I/O tristated until configured
    assign load_enable = (state_ff == cfg_hs_pkg::ST_LOAD) && !ce_n_s;

    // ==========================================================
    // checks
    // ==========================================================
    sequence s_load_done;
        state_ff == cfg_hs_pkg::ST_LOAD && !ce_n_s && stat_s && req_n_s &&
            !load_evt.data_err && load_evt.data_done;
    endsequence

    property p_done_low_loading;
        @(posedge ref_clk) disable iff (rst)
        state_ff == cfg_hs_pkg::ST_LOAD |-> config_complete_line_oe;
    endproperty
    a_done_low_loading: assert property (p_done_low_loading) else $error("done released early");

    property p_done_release;
        @(posedge ref_clk) disable iff (rst)
        s_load_done |=> !config_complete_line_oe && state_ff == cfg_hs_pkg::ST_INIT;
    endproperty
    a_done_release: assert property (p_done_release) else $error("done not released");

    property p_user_needs_done;
        @(posedge ref_clk) disable iff (rst)
        $rose(user_mode) |-> $past(done_s);
    endproperty
    a_user_needs_done: assert property (p_user_needs_done) else $error("user without done");

    property p_user_holds;
        @(posedge ref_clk) disable iff (rst)
        user_mode && req_n_s |=> user_mode;
    endproperty
    a_user_holds: assert property (p_user_holds) else $error("user mode lost");

    property p_no_load_disabled;
        @(posedge ref_clk) disable iff (rst)
        ce_n_s |-> !load_enable;
    endproperty
    a_no_load_disabled: assert property (p_no_load_disabled) else $error("load while disabled");

    property p_status_por;
        @(posedge ref_clk) disable iff (rst)
        state_ff == cfg_hs_pkg::ST_POR && !cnt_zero |=> config_status_n_oe;
    endproperty
    a_status_por: assert property (p_status_por) else $error("status released in por");

    property p_error_status;
        @(posedge ref_clk) disable iff (rst)
        state_ff == cfg_hs_pkg::ST_LOAD && load_evt.data_err |=> config_status_n_oe [*2];
    endproperty
    a_error_status: assert property (p_error_status) else $error("error not flagged");

    property p_request_reset;
        @(posedge ref_clk) disable iff (rst)
        !req_n_s && state_ff != cfg_hs_pkg::ST_POR |=> !user_io_oe && config_complete_line_oe;
    endproperty
    a_request_reset: assert property (p_request_reset) else $error("request not honoured");

    property p_ceo;
        @(posedge ref_clk) disable iff (rst)
        chain_enable_out_n == !user_mode;
    endproperty
    a_ceo: assert property (p_ceo) else $error("chain out mismatch");

endmodule // config_status_handshake

// ===== cfg_hs_pkg.sv
// package for the configuration status/done handshake block
// assumes a single 25 MHz clock and that data-path logic reports progress
package cfg_hs_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 40;           // ref_clk period
    localparam int POR_TIME_US = 12;             // power-on reset interval
    // cycles of the power-on interval, rounded up
    localparam int POR_CYCLES = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_TIME_NS = 400;           // initialization cycle length
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;                   // width of the sequence counter

    // ==========================================================
    // sequencer states, one-hot
    // ==========================================================
    typedef enum logic [6:0] {
        ST_POR    = 7'h01,   // power-on interval, status held low
        ST_IDLE   = 7'h02,   // waiting for chain enable and request high
        ST_LOAD   = 7'h04,   // receiving configuration data
        ST_INIT   = 7'h08,   // done released, waiting for line high
        ST_USER   = 7'h10,   // user mode
        ST_ERROR  = 7'h20,   // error, status held low
        ST_RESET  = 7'h40    // request low: configuration discarded
    } cfg_state_t;

    // progress reported by the data path
    typedef struct packed {
        logic data_done;     // all data received
        logic data_err;      // error seen in the data
    } load_evt_t;

endpackage

// ===== cfg_host_model.sv
// behavioural model of the external configuration host and board pull-ups
// assumes open-drain status and done pins, each with a pull-up to high
module cfg_host_model (
    input wire logic status_oe,          // device pulling status low
    input wire logic done_oe,            // device pulling done low
    input wire logic req_n_set,          // bench choice of request level
    input wire logic ce_n_set,           // bench choice of chain enable
    input wire logic status_pull,        // host pulls status low
    input wire logic done_pull,          // another chained part holds done low
    output logic config_request_n,       // request pin to the device
    output logic chain_enable_in_n,      // chain enable pin to the device
    output logic status_line,            // resolved status pin level
    output logic done_line               // resolved done pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // wired-and pins
    // ==========================================================
    // pull-up wins only when nobody pulls low, so no stale value lingers
    assign status_line = ~(status_oe | status_pull);
    assign done_line = ~(done_oe | done_pull);
    // first device of a chain: tied low unless a test says otherwise
    assign chain_enable_in_n = ce_n_set;
    assign config_request_n = req_n_set;
endmodule // cfg_host_model

// ===== test_config_status_handshake.sv
// self-checking bench for the status, done and chain enable sequencer
// assumes the host model file and the design package are compiled first
module test_config_status_handshake;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    // ==========================================================
    logic ref_clk, rst, req_n, ce_n, st_pull, dn_pull; // bench-driven
    cfg_hs_pkg::load_evt_t evt;      // data path progress
    logic rq_n, ce_in_n, st_line, dn_line, st_out, st_oe, dn_out, dn_oe;
    logic ceo_n, ld_en, usr, io_oe;  // observed outputs
    int err_total, tests_run;        // tallies
    typedef struct packed {
        logic err;                   // inject data error
        logic hold;                  // hold done low from outside
        logic exp;                   // expected user mode
    } row_t;
    row_t rows [3] = '{'{1'b0, 1'b0, 1'b1}, '{1'b1, 1'b0, 1'b0}, '{1'b0, 1'b1, 1'b0}};
    cfg_host_model host (.status_oe(st_oe), .done_oe(dn_oe), .req_n_set(req_n),
        .ce_n_set(ce_n), .status_pull(st_pull), .done_pull(dn_pull),
        .config_request_n(rq_n), .chain_enable_in_n(ce_in_n),
        .status_line(st_line), .done_line(dn_line));
    config_status_handshake DUT (.ref_clk(ref_clk), .rst(rst), .config_request_n(rq_n),
        .chain_enable_in_n(ce_in_n), .config_status_n_in(st_line),
        .config_status_n_out(st_out), .config_status_n_oe(st_oe),
        .config_complete_line_in(dn_line), .config_complete_line_out(dn_out),
        .config_complete_line_oe(dn_oe), .chain_enable_out_n(ceo_n), .load_evt(evt),
        .load_enable(ld_en), .user_mode(usr), .user_io_oe(io_oe));
    // ==========================================================
    // helpers
    // ==========================================================
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    // inputs always move 5 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    // bounded wait: request sync, idle step, status sync and load step take six edges
    task automatic wait_load();
        for (int i = 0; i < 20 && ld_en !== 1'b1; i++) tick(1);
    endtask
    // request pulse discards everything before a new attempt
    task automatic req_pulse();
        req_n = 1'b0;
        tick(4);
        chk("user_io_oe", 1'b0, io_oe);
        chk("done_oe", 1'b1, dn_oe);
        req_n = 1'b1;
    endtask
    // ==========================================================
    // watchdog: whole run is well under 1500 cycles
    // ==========================================================
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        err_total = 0;
        tests_run = 0;
        {rst, req_n, ce_n, st_pull, dn_pull} = 5'h10;
        req_n = 1'b1;
        evt = '0;
        tick(8);
        chk("status_oe", 1'b1, st_oe);
        chk("ceo_n", 1'b1, ceo_n);
        chk("status_out", 1'b0, st_out);
        chk("done_out", 1'b0, dn_out);
        rst = 1'b0;
        tick(250);
        chk("status_oe", 1'b1, st_oe);
        chk("load_enable", 1'b0, ld_en);
        chk("user_mode", 1'b0, usr);
        tick(60);
        chk("status_oe", 1'b0, st_oe);
        // ordinary attempts: clean, data error, done held by a neighbour
        foreach (rows[i]) begin
            req_pulse();
            dn_pull = rows[i].hold;
            wait_load();
            chk("load_enable", 1'b1, ld_en);
            evt = rows[i].err ? 2'h1 : 2'h2;
            tick(1);
            evt = '0;
            tick(2);
            chk("done_oe", rows[i].err, dn_oe);
            chk("status_oe", rows[i].err, st_oe);
            tick(14);
            chk("user_mode", rows[i].exp, usr);
            chk("user_io_oe", rows[i].exp, io_oe);
            if (rows[i].hold) begin
                dn_pull = 1'b0;
                tick(4);
                chk("user_mode", 1'b1, usr);
            end
        end
        // user mode shrugs off both pins being pulled low
        {st_pull, dn_pull} = 2'h3;
        tick(6);
        chk("user_mode", 1'b1, usr);
        chk("status_oe", 1'b0, st_oe);
        chk("ceo_n", 1'b0, ceo_n);
        {st_pull, dn_pull} = 2'h0;
        // chain enable high blocks loading
        req_pulse();
        ce_n = 1'b1;
        tick(8);
        chk("load_enable", 1'b0, ld_en);
        ce_n = 1'b0;
        wait_load();
        // outside pull on status while loading is an error
        st_pull = 1'b1;
        tick(4);
        st_pull = 1'b0;
        tick(2);
        chk("status_oe", 1'b1, st_oe);
        chk("load_enable", 1'b0, ld_en);
        chk("status_out", 1'b0, st_out);
        chk("done_out", 1'b0, dn_out);
        end_of_test();
    end
endmodule // test_config_status_handshake
